// ---- wprc_core.sv ----
// Receiver comm, power report, thermistor and alignment logic
// What this block does
// R01 - Shut down when thermistor voltage sits between upper and lower comparator levels.
// R02 - Below lower level, flag end of charge and send end-power packets.
// R03 - Present misalignment per axis as signed 8-bit magnitude and direction.
// R04 - Sign of each axis value comes from phase against the power signal.
// R05 - In power transfer, send a received-power packet periodically.
// R06 - Reported power is estimate plus a 750 mW accuracy margin.
// R07 - Offset input code maps to roughly minus 1.76 W to plus 2.34 W.
// R08 - Gain input code maps to factor roughly 0 to 2.33.
// R09 - Both calibration inputs grounded disables compensation.
// R10 - Report is power times gain over 1755, plus offset, minus 1755.
// R11 - Send bits by grounding both coil nodes through capacitors at 2 kbps.
// R12 - Transmitter shifts frequency in runs of 256 power cycles.
// R13 - Only positive FSK: shifted frequency is always the higher one.
// R14 - Transmitter answers only after our packet, with under 1% deviation.
// R15 - Periods counted at 60 MHz; shifted period is 3 counts shorter.
// R16 - Start bit is 512 shifted cycles, read as zero.
// R17 - One is 256 plus 256 at differing levels; zero is 512 at one.
// R18 - FSK bytes framed as start, data, parity, stop.
// R19 - ASK uses differential bi-phase on 2 kHz; one toggles mid-bit.
// R20 - Each byte is start, eight data, parity, stop: eleven bits.
// R21 - Packet is preamble, header, message, checksum in order.
// R22 - Odd parity per byte; checksum is xor of header and message.
// R23 - Classify periods against running base; drop bad parity or framing.
`timescale 1ns/1ns
module wprc_core #(
  parameter int ASK_HALF_CYC   = wprc_pkg::ASK_HALF_CYC,
  parameter int RPP_PERIOD_CYC = wprc_pkg::RPP_PERIOD_CYC,
  parameter logic [7:0] RPP_HEADER = 8'h01,
  parameter logic [7:0] EPT_HEADER = 8'h02,
  parameter logic [7:0] EPT_CODE   = 8'h00
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic                 coil_node_first_sense,
  input  wire logic                 horizontal_misalign_sense_phase,
  input  wire logic                 vertical_misalign_sense_phase,
  input  wire logic [6:0]           horizontal_misalign_sense_mag,
  input  wire logic [6:0]           vertical_misalign_sense_mag,
  input  wire logic                 thermistor_charge_end_input_above_hi,
  input  wire logic                 thermistor_charge_end_input_below_lo,
  input  wire logic [11:0]          power_report_offset_input,
  input  wire logic [11:0]          power_report_gain_input,
  input  wire logic [15:0]          estimated_received_power,
  input  wire logic                 power_transfer_phase,
  input  wire wprc_pkg::wprc_pkt_t  app_pkt,
  input  wire logic                 app_pkt_req,
  output wire logic                 app_pkt_ready,
  output wire logic                 coil_node_first_mod,
  output wire logic                 coil_node_second_mod,
  output wire logic                 tx_busy,
  output wire logic                 over_temp_shutdown,
  output wire logic                 end_of_charge,
  output wire logic signed [7:0]    horizontal_misalign,
  output wire logic signed [7:0]    vertical_misalign,
  output wire logic [15:0]          reported_power_mw,
  output wire wprc_pkg::wprc_rx_t   rx_byte
);
  // Timer widths bound the parameters
  if (ASK_HALF_CYC < 2 || ASK_HALF_CYC > 65535) begin : g_chk_ask
    $error("ASK_HALF_CYC out of range");
  end
  if (RPP_PERIOD_CYC < 2 || RPP_PERIOD_CYC > 16777215) begin : g_chk_rpp
    $error("RPP_PERIOD_CYC out of range");
  end
  localparam logic [15:0] HB_LAST  = 16'(ASK_HALF_CYC - 1);
  localparam logic [23:0] RPP_LAST = 24'(RPP_PERIOD_CYC - 1);

  typedef struct packed {
    logic [1:0]           pac_s;
    logic [1:0]           ax_s;
    logic [1:0]           ay_s;
    logic [1:0]           hi_s;
    logic [1:0]           lo_s;
    logic                 pac_d;
    logic [6:0]           acc;
    logic [15:0]          per_cnt;
    logic [15:0]          base;
    logic                 lvl;
    wprc_pkg::wprc_rx_st_t rx_st;
    logic [8:0]           slot;
    logic                 half;
    logic                 h0;
    logic [3:0]           rbit;
    logic [10:0]          rsh;
    logic                 armed;
    wprc_pkg::wprc_rx_t   rx;
    wprc_pkg::wprc_tx_st_t tx_st;
    logic [15:0]          hb;
    logic                 phase;
    logic                 cur;
    logic [3:0]           bidx;
    logic [3:0]           pre;
    logic [10:0]          sh;
    logic [2:0]           idx;
    logic [7:0]           chk;
    wprc_pkg::wprc_pkt_t  pkt;
    logic                 mod;
    logic [23:0]          rpp_tmr;
    logic                 rpp_due;
    logic                 shut;
    logic                 eoc;
    logic [7:0]           alx;
    logic [7:0]           aly;
    logic [15:0]          rpt;
  } wprc_state_t;

  wprc_state_t          st_r;
  wprc_state_t          st_nxt;
  logic                 pwr_rise;
  logic                 tick;
  logic                 mod_now;
  logic                 fod_off;
  logic [27:0]          prod;
  logic [27:0]          quot;
  logic [28:0]          total;
  logic [28:0]          rpt_full;
  logic [15:0]          rpt_val;

  // Power-signal edge from synchronised comparator
  assign pwr_rise = st_r.pac_s[1] & ~st_r.pac_d;
  // R15 sixty MHz tick
  assign tick = (st_r.acc >= (wprc_pkg::ACC_MOD - wprc_pkg::OSC_INC));
  // R13 R15 R23 shorter period means shifted
  assign mod_now = (st_r.base != 16'h0000) &&
                   (({1'b0, st_r.per_cnt} + wprc_pkg::FSK_TOL) <= {1'b0, st_r.base});

  // R07 R08 R10 codes scale power; divide is wide but only settles once a cycle
  assign prod  = 28'(estimated_received_power) * 28'(power_report_gain_input);
  assign quot  = prod / wprc_pkg::GAIN_UNITY;
  // R06 margin added before bias removal
  assign total = 29'(quot) + 29'(power_report_offset_input) + wprc_pkg::MARGIN_MW;
  // R09 grounded pins bypass compensation
  assign fod_off  = (power_report_offset_input == 12'h000) && (power_report_gain_input == 12'h000);
  assign rpt_full = fod_off ? (29'(estimated_received_power) + wprc_pkg::MARGIN_MW) :
                    (total < wprc_pkg::OFFSET_BIAS) ? 29'h0000000 : total - wprc_pkg::OFFSET_BIAS;
  // Saturate rather than wrap so a big load never reports as small
  assign rpt_val  = (rpt_full > wprc_pkg::RPT_MAX) ? 16'hFFFF : rpt_full[15:0];

  // Host packet accepted only when nothing of higher priority waits
  assign app_pkt_ready = (st_r.tx_st == wprc_pkg::TX_IDLE) && !st_r.eoc && !st_r.rpp_due;

  // Next-state logic for the whole block
  always_comb begin
    wprc_pkg::wprc_pkt_t pkt_sel;
    logic                load;
    logic                bit_start;
    logic                rbit_v;
    logic [10:0]         frm;
    logic [7:0]          nb;
    pkt_sel   = '0;
    load      = 1'b0;
    bit_start = 1'b0;
    rbit_v    = 1'b0;
    frm       = '0;
    nb        = '0;
    st_nxt    = st_r;
    // Two-stage synchronisers for pin inputs
    st_nxt.pac_s = {st_r.pac_s[0], coil_node_first_sense};
    st_nxt.ax_s  = {st_r.ax_s[0], horizontal_misalign_sense_phase};
    st_nxt.ay_s  = {st_r.ay_s[0], vertical_misalign_sense_phase};
    st_nxt.hi_s  = {st_r.hi_s[0], thermistor_charge_end_input_above_hi};
    st_nxt.lo_s  = {st_r.lo_s[0], thermistor_charge_end_input_below_lo};
    st_nxt.pac_d = st_r.pac_s[1];
    // R01 window between the two comparators
    st_nxt.shut = ~st_r.hi_s[1] & ~st_r.lo_s[1];
    // R02 end of charge below lower level
    st_nxt.eoc  = st_r.lo_s[1];
    st_nxt.rpt  = rpt_val;
    // R15 phase accumulator yields 60 ticks per 100 clocks
    st_nxt.acc = tick ? st_r.acc + wprc_pkg::OSC_INC - wprc_pkg::ACC_MOD
                      : st_r.acc + wprc_pkg::OSC_INC;
    if (tick && st_r.per_cnt != 16'hFFFF) begin
      st_nxt.per_cnt = st_r.per_cnt + 16'h0001;
    end
    if (pwr_rise) begin
      st_nxt.per_cnt = 16'h0000;
      st_nxt.lvl     = mod_now;
      // R23 base follows unshifted periods only
      if (!mod_now) begin
        st_nxt.base = st_r.per_cnt;
      end
      // R03 R04 sign from axis phase at power edge
      st_nxt.alx = st_r.ax_s[1] ? {1'b0, horizontal_misalign_sense_mag}
                                : 8'h00 - {1'b0, horizontal_misalign_sense_mag};
      st_nxt.aly = st_r.ay_s[1] ? {1'b0, vertical_misalign_sense_mag}
                                : 8'h00 - {1'b0, vertical_misalign_sense_mag};
    end

    // FSK bit and byte recovery
    st_nxt.rx = '0;
    case (st_r.rx_st)
      wprc_pkg::RX_IDLE: begin
        // R14 R16 listen after our packet, start on shifted cycles
        if (pwr_rise && mod_now && st_r.armed && st_r.tx_st == wprc_pkg::TX_IDLE) begin
          st_nxt.rx_st = wprc_pkg::RX_RUN;
          st_nxt.slot  = 9'h001;
          st_nxt.half  = 1'b0;
          st_nxt.rbit  = 4'h0;
        end
      end
      wprc_pkg::RX_RUN: begin
        if (pwr_rise) begin
          // R12 R17 half-bit slots of 256 cycles
          if (st_r.slot == wprc_pkg::SLOT_LAST) begin
            st_nxt.slot = 9'h000;
            st_nxt.half = ~st_r.half;
            if (!st_r.half) begin
              st_nxt.h0 = mod_now;
            end else begin
              // R17 level change mid-bit means one
              rbit_v      = st_r.h0 ^ mod_now;
              frm         = {rbit_v, st_r.rsh[10:1]};
              st_nxt.rsh  = frm;
              st_nxt.rbit = st_r.rbit + 4'h1;
              // R16 start bit must decode as zero
              if (st_r.rbit == 4'h0 && rbit_v) begin
                st_nxt.rx.err = 1'b1;
                st_nxt.rx_st  = wprc_pkg::RX_IDLE;
              end else if (st_r.rbit == wprc_pkg::BYTE_BITS - 4'h1) begin
                st_nxt.rx_st = wprc_pkg::RX_IDLE;
                // R18 R22 R23 stop and odd parity checked
                if (frm[10] && (^frm[9:1])) begin
                  st_nxt.rx.valid = 1'b1;
                  st_nxt.rx.data  = frm[8:1];
                end else begin
                  st_nxt.rx.err = 1'b1;
                end
              end
            end
          end else begin
            st_nxt.slot = st_r.slot + 9'h001;
          end
        end
      end
      default: st_nxt.rx_st = wprc_pkg::RX_IDLE;
    endcase

    // ASK packet transmitter
    case (st_r.tx_st)
      wprc_pkg::TX_IDLE: begin
        // R02 end-power packets repeat while end of charge holds
        if (st_r.eoc) begin
          pkt_sel.header = EPT_HEADER;
          pkt_sel.len    = 3'h1;
          pkt_sel.msg[0] = EPT_CODE;
          load           = 1'b1;
        // R05 periodic received-power packet
        end else if (st_r.rpp_due) begin
          pkt_sel.header = RPP_HEADER;
          pkt_sel.len    = 3'h2;
          pkt_sel.msg[0] = st_r.rpt[15:8];
          pkt_sel.msg[1] = st_r.rpt[7:0];
          st_nxt.rpp_due = 1'b0;
          load           = 1'b1;
        end else if (app_pkt_req) begin
          pkt_sel = app_pkt;
          if (app_pkt.len > 3'(wprc_pkg::MSG_MAX)) begin
            pkt_sel.len = 3'(wprc_pkg::MSG_MAX);
          end
          load = 1'b1;
        end
        // R21 preamble leads every packet
        if (load) begin
          st_nxt.pkt   = pkt_sel;
          st_nxt.tx_st = wprc_pkg::TX_PRE;
          st_nxt.pre   = 4'(wprc_pkg::PRE_BITS - 1);
          st_nxt.cur   = 1'b1;
          st_nxt.chk   = pkt_sel.header;
          st_nxt.idx   = 3'h0;
          st_nxt.phase = 1'b0;
          st_nxt.hb    = HB_LAST;
          bit_start    = 1'b1;
        end
      end
      wprc_pkg::TX_PRE, wprc_pkg::TX_BYTE: begin
        if (st_r.hb != 16'h0000) begin
          st_nxt.hb = st_r.hb - 16'h0001;
        end else begin
          st_nxt.hb    = HB_LAST;
          st_nxt.phase = ~st_r.phase;
          if (!st_r.phase) begin
            // R19 a one toggles again mid-bit
            if (st_r.cur) begin
              st_nxt.mod = ~st_r.mod;
            end
          end else if (st_r.tx_st == wprc_pkg::TX_PRE) begin
            bit_start = 1'b1;
            if (st_r.pre != 4'h0) begin
              st_nxt.pre = st_r.pre - 4'h1;
            end else begin
              // R20 R21 header byte follows preamble
              frm          = wprc_pkg::wprc_frame(st_r.pkt.header);
              st_nxt.tx_st = wprc_pkg::TX_BYTE;
              st_nxt.sh    = frm;
              st_nxt.bidx  = 4'h0;
              st_nxt.cur   = frm[0];
            end
          end else if (st_r.bidx != wprc_pkg::BYTE_BITS - 4'h1) begin
            bit_start   = 1'b1;
            st_nxt.bidx = st_r.bidx + 4'h1;
            st_nxt.sh   = {1'b0, st_r.sh[10:1]};
            st_nxt.cur  = st_r.sh[1];
          end else if (st_r.idx <= st_r.pkt.len) begin
            // R21 R22 message bytes then xor checksum
            nb          = (st_r.idx == st_r.pkt.len) ? st_r.chk : st_r.pkt.msg[st_r.idx[1:0]];
            frm         = wprc_pkg::wprc_frame(nb);
            bit_start   = 1'b1;
            st_nxt.chk  = st_r.chk ^ nb;
            st_nxt.idx  = st_r.idx + 3'h1;
            st_nxt.sh   = frm;
            st_nxt.bidx = 4'h0;
            st_nxt.cur  = frm[0];
          end else begin
            // Return switches open; arm the listener for the reply
            st_nxt.tx_st = wprc_pkg::TX_IDLE;
            st_nxt.mod   = 1'b0;
            st_nxt.armed = 1'b1;
          end
        end
      end
      default: st_nxt.tx_st = wprc_pkg::TX_IDLE;
    endcase
    // R19 every bit starts with a transition
    if (bit_start) begin
      st_nxt.mod = ~st_r.mod;
    end

    // R05 report timer runs only during power transfer
    if (!power_transfer_phase) begin
      st_nxt.rpp_tmr = RPP_LAST;
      st_nxt.rpp_due = 1'b0;
    end else if (st_r.rpp_tmr == 24'h000000) begin
      st_nxt.rpp_tmr = RPP_LAST;
      st_nxt.rpp_due = 1'b1;
    end else begin
      st_nxt.rpp_tmr = st_r.rpp_tmr - 24'h000001;
    end
  end

  // Single state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r         <= '0;
      st_r.rpp_tmr <= RPP_LAST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // R11 both coil nodes switched together
  assign coil_node_first_mod  = st_r.mod;
  assign coil_node_second_mod = st_r.mod;
  assign tx_busy              = (st_r.tx_st != wprc_pkg::TX_IDLE);
  assign over_temp_shutdown   = st_r.shut;
  assign end_of_charge        = st_r.eoc;
  // R03 signed axis values
  assign horizontal_misalign  = st_r.alx;
  assign vertical_misalign    = st_r.aly;
  assign reported_power_mw    = st_r.rpt;
  assign rx_byte              = st_r.rx;

  // Helper: cycles since last modulation change
  logic        mod_d_r;
  logic [16:0] gap_r;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mod_d_r <= 1'b0;
      gap_r   <= 17'h00000;
    end else begin
      mod_d_r <= st_r.mod;
      gap_r   <= (st_r.mod != mod_d_r) ? 17'h00001 : gap_r + 17'h00001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  ots_window_a: assert property ( // R01
    (!thermistor_charge_end_input_above_hi && !thermistor_charge_end_input_below_lo) [*4]
    |=> over_temp_shutdown) else $error("shutdown missing in thermistor window");
  eoc_ept_a: assert property ( // R02
    (end_of_charge && st_r.tx_st == wprc_pkg::TX_IDLE)
    |=> (st_r.tx_st == wprc_pkg::TX_PRE && st_r.pkt.header == EPT_HEADER))
    else $error("end of charge did not start end-power packet");
  align_sign_a: assert property ( // R04
    (pwr_rise && horizontal_misalign_sense_mag != 7'h00)
    |=> (horizontal_misalign[7] == !$past(st_r.ax_s[1])))
    else $error("alignment sign does not follow phase");
  fod_bypass_a: assert property ( // R09
    fod_off |=> (reported_power_mw == 16'($past(estimated_received_power) + 16'h02EE)
                 || reported_power_mw == 16'hFFFF))
    else $error("grounded calibration did not bypass compensation");
  coil_pair_a: assert property ( // R11
    coil_node_first_mod == coil_node_second_mod) else $error("coil switches differ");
  half_bit_a: assert property ( // R19
    ((st_r.mod != mod_d_r) && $past(tx_busy))
    |-> (gap_r == 17'(ASK_HALF_CYC) || gap_r == 17'(2 * ASK_HALF_CYC)))
    else $error("ASK transition off the half-bit grid");
  tx_frame_a: assert property ( // R22
    (st_r.tx_st == wprc_pkg::TX_BYTE && st_r.bidx == 4'h0)
    |-> (!st_r.sh[0] && st_r.sh[10] && (^st_r.sh[9:1])))
    else $error("byte frame or parity wrong");
  fsk_class_a: assert property ( // R15
    (pwr_rise && st_r.base != 16'h0000 && ({1'b0, st_r.per_cnt} + 17'h00002) <= {1'b0, st_r.base})
    |=> st_r.lvl) else $error("short period not classed as shifted");
  rx_start_a: assert property ( // R16
    $rose(st_r.rx_st == wprc_pkg::RX_RUN) |-> $past(mod_now && pwr_rise && st_r.armed))
    else $error("receiver started without shifted cycle");

  pkt_done_c: cover property (tx_busy ##1 !tx_busy);
  rx_valid_c: cover property (rx_byte.valid);
  rx_err_c:   cover property (rx_byte.err);
  eoc_c:      cover property ($rose(end_of_charge));
endmodule : wprc_core

// ---- wprc_core_tb.sv ----
// Self-checking bench for the receiver comm block
`timescale 1ns/1ns
module wprc_core_tb;
  localparam int         HC = 8;
  localparam logic [7:0] RH = 8'h01;
  localparam logic [7:0] EH = 8'h02;
  localparam logic [7:0] EC = 8'h00;
  logic                ref_clk = 1'b0;
  logic                reset_n = 1'b0;
  logic                pwr, hph, vph, above, below, ptp, req, go;
  logic [6:0]          hmag, vmag;
  logic [11:0]         offs, gain;
  logic [15:0]         pmw;
  wprc_pkg::wprc_pkt_t pkt;
  logic                rdy, m1, m2, busy, ots, eoc;
  logic signed [7:0]   hmis, vmis;
  logic [15:0]         rpt;
  wprc_pkg::wprc_rx_t  rxb;
  int                  mismatches = 0;
  int                  n_checks = 0;
  int                  i;
  logic [15:0] pv [5] = '{16'h03E8, 16'h07D0, 16'h0000, 16'h03E8, 16'hFFFF};
  logic [11:0] gv [5] = '{12'h6DB, 12'hDB6, 12'h001, 12'h000, 12'hFFF};
  logic [11:0] ov [5] = '{12'h6DB, 12'h000, 12'h000, 12'h000, 12'hFFF};

  // Short ASK half-bit and report period keep the run short
  wprc_core #(.ASK_HALF_CYC(HC), .RPP_PERIOD_CYC(2000), .RPP_HEADER(RH),
    .EPT_HEADER(EH), .EPT_CODE(EC)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .coil_node_first_sense(pwr),
    .horizontal_misalign_sense_phase(hph), .vertical_misalign_sense_phase(vph),
    .horizontal_misalign_sense_mag(hmag), .vertical_misalign_sense_mag(vmag),
    .thermistor_charge_end_input_above_hi(above),
    .thermistor_charge_end_input_below_lo(below),
    .power_report_offset_input(offs), .power_report_gain_input(gain),
    .estimated_received_power(pmw), .power_transfer_phase(ptp), .app_pkt(pkt),
    .app_pkt_req(req), .app_pkt_ready(rdy), .coil_node_first_mod(m1),
    .coil_node_second_mod(m2), .tx_busy(busy), .over_temp_shutdown(ots),
    .end_of_charge(eoc), .horizontal_misalign(hmis), .vertical_misalign(vmis),
    .reported_power_mw(rpt), .rx_byte(rxb));
  // Far-side transmitter, carrier runs free
  wprc_tx_model tx (.ask_mod(m1), .fsk_go(go), .fsk_data(8'h96), .pwr_ac(pwr));

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic hang;
    mismatches++;
    $display("[FAIL] %0t wait ran out", $time);
    close_out();
  endtask : hang

  // Report expectation; grounded calibration pins skip the correction
  function automatic logic [15:0] rpp_exp(input int p, input int g, input int o);
    int e;
    e = p * g / 1755 + o - 1755 + 750;
    if (g == 0 && o == 0) e = p + 750;
    if (e < 0) e = 0;
    if (e > 65535) e = 65535;
    return 16'(e);
  endfunction : rpp_exp

  // Sample both halves of each ASK bit and check framing and checksum
  task automatic ask_pkt(input logic [7:0] hdr, input int n, input logic [31:0] msg);
    int          k;
    int          b;
    logic        h1, h2, prev;
    logic [10:0] fr;
    logic [7:0]  xs, e;
    k = 0;
    while (busy !== 1'b1) begin
      @(negedge ref_clk);
      k++;
      if (k > 5000) hang();
    end
    req = 1'b0;
    prev = 1'b0;
    xs = hdr;
    for (int j = 0; j < 11 * (n + 3); j++) begin
      repeat (HC / 2 - 1) @(negedge ref_clk);
      h1 = m1;
      chk(m2, m1);
      repeat (HC) @(negedge ref_clk);
      h2 = m1;
      repeat (HC / 2 + 1) @(negedge ref_clk);
      chk(h1, !prev);
      prev = h2;
      k = j % 11;
      b = j / 11 - 1;
      fr[k] = h1 ^ h2;
      if (j < 11) chk(fr[k], 1'b1);
      if (j >= 11 && k == 10) begin
        e = (b == 0) ? hdr : (b <= n) ? msg[8 * (b - 1) +: 8] : xs;
        if (b > 0 && b <= n) xs = xs ^ e;
        chk({fr[0], fr[10], ^fr[9:1]}, 3'b011);
        chk(fr[8:1], e);
      end
    end
    @(negedge ref_clk);
    if (eoc !== 1'b1) chk({busy, m1}, 2'b00);
  endtask : ask_pkt

  // Main sequence
  initial begin
    {hph, vph, below, ptp, req, go} = 6'h00;
    above = 1'b1;
    hmag = 7'h00;
    vmag = 7'h00;
    offs = 12'h6DB;
    gain = 12'h6DB;
    pmw = 16'h0000;
    pkt = '{8'h3C, 3'h5, 32'hA500FF81};
    @(negedge ref_clk);
    chk({m1, m2, busy, rdy, ots, eoc}, 6'h04);
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    hph = 1'b1;
    hmag = 7'h25;
    vmag = 7'h5A;
    repeat (40) @(negedge ref_clk);
    chk({hmis, vmis}, 16'h25A6);
    hph = 1'b0;
    vph = 1'b1;
    repeat (40) @(negedge ref_clk);
    chk({hmis, vmis}, 16'hDB5A);
    for (int r = 0; r < 5; r++) begin
      pmw = pv[r];
      gain = gv[r];
      offs = ov[r];
      repeat (3) @(negedge ref_clk);
      chk(rpt, rpp_exp(pv[r], gv[r], ov[r]));
    end
    // Length five is clipped to four bytes
    req = 1'b1;
    ask_pkt(8'h3C, 4, 32'hA500FF81);
    go = 1'b1;
    i = 0;
    while (rxb.valid !== 1'b1 && rxb.err !== 1'b1) begin
      @(negedge ref_clk);
      i++;
      if (i > 70000) hang();
    end
    chk(rxb, 10'h296);
    pmw = 16'h07D0;
    gain = 12'hDB6;
    offs = 12'h000;
    ptp = 1'b1;
    ask_pkt(RH, 2, 32'h0000B30B);
    chk(rpt, 16'h0BB3);
    ptp = 1'b0;
    above = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk({ots, eoc}, 2'b10);
    below = 1'b1;
    ask_pkt(EH, 1, {24'h000000, EC});
    chk({ots, eoc}, 2'b01);
    below = 1'b0;
    above = 1'b1;
    close_out();
  end
endmodule : wprc_core_tb

// ---- wprc_pkg.sv ----
// Shared constants, carrier types and helpers for the wireless power receiver comm block
package wprc_pkg;
  // Clock and period-measuring oscillator, in kHz
  localparam int          CLK_KHZ     = 100000;
  localparam int          OSC_KHZ     = 60000;
  localparam logic [6:0]  ACC_MOD     = 7'(CLK_KHZ / 1000);
  localparam logic [6:0]  OSC_INC     = 7'(OSC_KHZ / 1000);
  // ASK link timing
  localparam int          ASK_BPS     = 2000;
  localparam int          ASK_HALF_CYC = (CLK_KHZ * 1000) / (2 * ASK_BPS);
  localparam int          PRE_BITS    = 11;
  // FSK link timing, in power-signal cycles and oscillator counts
  localparam int          FSK_HALF_CYC = 256;
  localparam logic [8:0]  SLOT_LAST   = 9'(FSK_HALF_CYC - 1);
  localparam int          FSK_SHIFT   = 3;
  localparam logic [16:0] FSK_TOL     = 17'(FSK_SHIFT - 1);
  // Serial byte framing
  localparam int          DATA_BITS   = 8;
  localparam logic [3:0]  BYTE_BITS   = 4'(DATA_BITS + 3);
  localparam int          MSG_MAX     = 4;
  // Received power report arithmetic
  localparam logic [27:0] GAIN_UNITY  = 28'h00006DB;
  localparam logic [28:0] OFFSET_BIAS = 29'h00006DB;
  localparam int          CODE_W      = 12;
  localparam logic [28:0] MARGIN_MW   = 29'h00002EE;
  localparam logic [28:0] RPT_MAX     = 29'h000FFFF;
  // Periodic power report
  localparam int          RPP_PERIOD_MS = 100;
  localparam int          RPP_PERIOD_CYC = RPP_PERIOD_MS * CLK_KHZ;

  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_BYTE} wprc_tx_st_t;
  typedef enum logic {RX_IDLE, RX_RUN} wprc_rx_st_t;

  // Outgoing packet: header, message length, message bytes
  typedef struct packed {
    logic [7:0]               header;
    logic [2:0]               len;
    logic [MSG_MAX-1:0][7:0]  msg;
  } wprc_pkt_t;

  // Demodulated byte with one-cycle strobes
  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } wprc_rx_t;

  // Start, data LSB first, odd parity, stop
  function automatic logic [10:0] wprc_frame(input logic [7:0] b);
    return {1'b1, ~^b, b, 1'b0};
  endfunction : wprc_frame
endpackage : wprc_pkg

// ---- wprc_tx_model.sv ----
// Behavioural power transmitter: carrier and FSK byte sender
`timescale 1ns/1ns
module wprc_tx_model #(
  parameter int BASE_HALF = 60,
  parameter int MOD_HALF  = 35
) (
  input  wire logic       ask_mod,
  input  wire logic       fsk_go,
  input  wire logic [7:0] fsk_data,
  output logic            pwr_ac
);
  logic        heard = 1'b0;
  logic        sent  = 1'b0;
  logic        lvl;
  logic [10:0] fr;
  always @(posedge ask_mod) heard = 1'b1;
  // Short carrier keeps the run brief, so deviation is far above one percent
  // shifted cycle 50 ns shorter
  task automatic cyc(input logic m, input int n);
    repeat (n) begin
      pwr_ac = 1'b1;
      #(m ? MOD_HALF : BASE_HALF);
      pwr_ac = 1'b0;
      #(m ? MOD_HALF : BASE_HALF);
    end
  endtask : cyc
  initial begin
    pwr_ac = 1'b0;
    forever begin
      if (fsk_go && heard && !sent) begin
        fr = {1'b1, ~^fsk_data, fsk_data, 1'b0};
        lvl = 1'b0;
        for (int i = 0; i < 11; i++) begin
          lvl = ~lvl;
          cyc(lvl, 256);
          lvl = lvl ^ fr[i];
          cyc(lvl, 256);
        end
        sent = 1'b1;
      end else begin
        cyc(1'b0, 1);
      end
    end
  end
endmodule : wprc_tx_model
